// ---- set_features_subcommand_decoder.sv ----
// Purpose: executes set-features subcommands written through APB task registers
// Assumes: one clock, zero-wait APB slave, command runs in the write's access edge
// Notes:   the read word is captured in the setup cycle so prdata is a flop
module set_features_subcommand_decoder
    import setfeat_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    // task file and control state
    logic [7:0]  feat_q, cnt_q, snum_q, lbalo_q, lbamid_q, lbahi_q;
    logic [2:0]  ctl_q;
    logic [EPC_IW-1:0] epc_idx_q;
    logic        abort_q;
    logic [7:0]  xfer_q, xfer_d;
    logic        wce_q, wce_d, rla_q, rla_d, revert_q, revert_d;
    logic [7:0]  link_q, link_d;
    logic [7:0]  lvl_q, lvl_d;
    pm_state_t   pm_q, pm_d;
    logic [8:0]  y1_q, y1_d;
    logic [12:0] y2_q, y2_d;
    logic        y1set_q, y1set_d;
    logic [15:0] pio_t_q, pio_t_d, dma_t_q, dma_t_d;
    logic [EPC_TW-1:0] cur_t_q [EPC_N];
    logic [EPC_TW-1:0] sav_t_q [EPC_N];
    logic [EPC_TW-1:0] cur_t_d [EPC_N];
    logic [EPC_TW-1:0] sav_t_d [EPC_N];
    logic [EPC_N-1:0]  cur_e_q, cur_e_d, sav_e_q;
    logic        abort_d;
    logic [31:0] rdata_w;

    // id to condition mask; bit EPC_N flags a supported selection
    function automatic logic [EPC_N:0] epc_select(input logic [7:0] id);
        logic [EPC_N:0] r;
        r = '0;
        if (id == EPC_ALL_IDS) begin
            r = {1'b1, EPC_SUPP};
        end else if (id < 8'(EPC_N)) begin
            r[id[EPC_IW-1:0]] = 1'b1;
            r[EPC_N]          = EPC_SUPP[id[EPC_IW-1:0]];
        end
        return r;
    endfunction

    // transfer mode legality
    function automatic logic xfer_ok(input logic [7:0] v);
        logic [4:0] t;
        logic [2:0] m;
        t = v[7:3];
        m = v[2:0];
        return (t == XT_PIO_DEF && m <= PIO_DEF_MAX) ||
               (t == XT_PIO_FC  && m <= PIO_FC_MAX)  ||
               (t == XT_MDMA    && m <= MDMA_MAX)    ||
               (t == XT_UDMA    && m <= UDMA_MAX);
    endfunction

    // bus decode
    wire setup_w    = psel & ~penable;
    wire access_w   = psel & penable & pready;
    wire wr_w       = access_w & pwrite;
    wire mapped_w   = (paddr <= A_EPC_SAV) && (paddr[1:0] == 2'b00);
    wire wr_ok_w    = wr_w & mapped_w;
    wire cmd_go_w   = wr_ok_w && paddr == A_COMMAND && pwdata[7:0] == CMD_SET_FEATURES;
    wire commit_w   = cmd_go_w & ~abort_d;
    wire soft_rst_w = wr_ok_w && paddr == A_CONTROL && pwdata[CTL_SRST];
    wire apm_init_w = soft_rst_w & revert_q;
    wire full_w     = ctl_q[CTL_FULL];
    wire epc_en_w   = ctl_q[CTL_EPC];

    // restore subcommand decode
    wire [EPC_N:0]   sel_w   = epc_select(cnt_q);
    wire [EPC_N-1:0] mask_w  = sel_w[EPC_N-1:0];
    wire             dflt_w  = snum_q[SN_DFLT_BIT];
    wire             save_w  = snum_q[SN_SAVE_BIT];
    wire             epc_bad_w = (snum_q[3:0] != EPC_SUB_RST) || !sel_w[EPC_N] ||
                                 ((mask_w & ~EPC_SUPP) != '0) ||
                                 ((mask_w & ~EPC_CHG) != '0) || !epc_en_w ||
                                 (save_w && (mask_w & ~EPC_SAVABLE) != '0);

    // power management delay arithmetic
    wire [7:0]  lpi_off_w  = 8'(cnt_q - LVL_LPI_LO);
    wire [7:0]  lrpm_off_w = 8'(cnt_q - LVL_LRPM_MID);
    wire [8:0]  y1_calc_w  = 9'({1'b0, lpi_off_w} * Y1_STEP_S + Y1_BASE_S);
    wire [12:0] y2_calc_w  = 13'({5'h00, lrpm_off_w} * Y2_STEP_S + Y2_BASE_S);

    // subcommand execution: next settings and abort decision
    always_comb begin
        abort_d  = 1'b0;
        xfer_d   = xfer_q;
        wce_d    = wce_q;
        rla_d    = rla_q;
        revert_d = revert_q;
        link_d   = link_q;
        lvl_d    = lvl_q;
        pm_d     = pm_q;
        y1_d     = y1_q;
        y2_d     = y2_q;
        y1set_d  = y1set_q;
        pio_t_d  = pio_t_q;
        dma_t_d  = dma_t_q;
        cur_t_d  = cur_t_q;
        cur_e_d  = cur_e_q;
        sav_t_d  = sav_t_q;
        case (feat_q)
            FC_XFER_MODE: begin
                xfer_d  = cnt_q;
                abort_d = !xfer_ok(cnt_q);
            end
            FC_WCACHE_ON: begin
                wce_d = ~full_w;
            end
            FC_WCACHE_OFF: begin
                wce_d = 1'b0;
            end
            FC_LINK_ON, FC_LINK_OFF: begin
                abort_d = (cnt_q > 8'h07) || !LINK_ID_OK[cnt_q[2:0]];
                link_d[cnt_q[2:0]] = (feat_q == FC_LINK_ON);
            end
            FC_APM_ON: begin
                lvl_d = cnt_q;
                if (cnt_q == LVL_ABORT_LO || cnt_q == LVL_ABORT_HI) begin
                    abort_d = 1'b1;
                end else if (cnt_q >= LVL_IDLE_LO) begin
                    pm_d    = PM_IDLE;
                    y1_d    = '0;
                    y2_d    = '0;
                    y1set_d = 1'b0;
                end else if (cnt_q >= LVL_LPI_LO) begin
                    pm_d    = PM_LPI;
                    y1_d    = y1_calc_w;
                    y2_d    = '0;
                    y1set_d = 1'b1;
                end else begin
                    pm_d    = PM_LRPM;
                    y2_d    = (cnt_q >= LVL_LRPM_MID) ? y2_calc_w : Y2_BASE_S;
                    y1_d    = y1set_q ? y1_q : Y1_BASE_S;
                    y1set_d = 1'b1;
                end
            end
            FC_APM_OFF: begin
                pm_d    = PM_IDLE;
                y1_d    = '0;
                y2_d    = '0;
                y1set_d = 1'b0;
            end
            FC_SECTOR_TIME: begin
                pio_t_d = {lbalo_q, cnt_q};
                dma_t_d = {lbahi_q, lbamid_q};
            end
            FC_EPC: begin
                abort_d = epc_bad_w;
                for (int i = 0; i < EPC_N; i++) begin
                    if (mask_w[i]) begin
                        cur_t_d[i] = dflt_w ? ((i == 0) ? EPC_DEF_T0 : EPC_DEF_T1)
                                            : sav_t_q[i];
                        cur_e_d[i] = dflt_w ? EPC_DEF_EN[i] : sav_e_q[i];
                        if (save_w && EPC_SAVABLE[i]) begin
                            sav_t_d[i] = cur_t_d[i];
                        end
                    end
                end
            end
            FC_RLA_ON: begin
                rla_d = 1'b1;
            end
            FC_RLA_OFF: begin
                rla_d = 1'b0;
            end
            FC_REVERT_ON: begin
                revert_d = 1'b1;
            end
            FC_REVERT_OFF: begin
                revert_d = 1'b0;
            end
            FC_PUIS_ON, FC_PUIS_OFF, FC_PUIS_SPIN: begin
                abort_d = 1'b0;
            end
            default: begin
                abort_d = 1'b1;
            end
        endcase
    end

    // read selection
    assign rdata_w =
        (paddr == A_FEATURE) ? {24'h0, feat_q} :
        (paddr == A_SECCNT)  ? {24'h0, cnt_q} :
        (paddr == A_SECNUM)  ? {24'h0, snum_q} :
        (paddr == A_LBALO)   ? {24'h0, lbalo_q} :
        (paddr == A_LBAMID)  ? {24'h0, lbamid_q} :
        (paddr == A_LBAHI)   ? {24'h0, lbahi_q} :
        (paddr == A_STATUS)  ? {24'h0, 8'(1 << ST_RDY) | 8'(1 << ST_SEEK) |
                                        8'({7'h0, abort_q} << ST_ERR)} :
        (paddr == A_ERROR)   ? {24'h0, 8'({7'h0, abort_q} << ER_ABT)} :
        (paddr == A_XFER)    ? {24'h0, xfer_q} :
        (paddr == A_FEATST)  ? {21'h0, revert_q, rla_q, wce_q, link_q} :
        (paddr == A_APM)     ? {22'h0, pm_q, lvl_q} :
        (paddr == A_DELAYS)  ? {3'h0, y2_q, 7'h0, y1_q} :
        (paddr == A_SECTIME) ? {dma_t_q, pio_t_q} :
        (paddr == A_CONTROL) ? {29'h0, ctl_q} :
        (paddr == A_EPC_IDX) ? {31'h0, epc_idx_q} :
        (paddr == A_EPC_CUR) ? {7'h0, cur_e_q[epc_idx_q], cur_t_q[epc_idx_q]} :
        (paddr == A_EPC_SAV) ? {7'h0, sav_e_q[epc_idx_q], sav_t_q[epc_idx_q]} :
        32'h0;

    // apb handshake: zero wait, read word captured in setup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            if (setup_w) begin
                prdata  <= pwrite ? 32'h0 : rdata_w;
                pslverr <= !mapped_w;
            end
        end
    end

    // task file and control writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            feat_q <= '0; cnt_q <= '0; snum_q <= '0;
            lbalo_q <= '0; lbamid_q <= '0; lbahi_q <= '0;
            ctl_q <= '0; epc_idx_q <= '0;
        end else if (wr_ok_w) begin
            if (paddr == A_FEATURE) feat_q <= pwdata[7:0];
            if (paddr == A_SECCNT)  cnt_q <= pwdata[7:0];
            if (paddr == A_SECNUM)  snum_q <= pwdata[7:0];
            if (paddr == A_LBALO)   lbalo_q <= pwdata[7:0];
            if (paddr == A_LBAMID)  lbamid_q <= pwdata[7:0];
            if (paddr == A_LBAHI)   lbahi_q <= pwdata[7:0];
            if (paddr == A_CONTROL) ctl_q <= {1'b0, pwdata[CTL_EPC:CTL_FULL]};
            if (paddr == A_EPC_IDX) epc_idx_q <= pwdata[EPC_IW-1:0];
        end
    end

    // completion status: error only on abort
    always_ff @(posedge clk or posedge rst) begin
        if (rst) abort_q <= 1'b0;
        else if (cmd_go_w) abort_q <= abort_d;
    end

    // plain feature settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_q <= XFER_RESET; wce_q <= 1'b1; rla_q <= 1'b1;
            revert_q <= 1'b0; link_q <= LINK_RESET;
            pio_t_q <= '0; dma_t_q <= '0;
        end else begin
            if (commit_w) begin
                xfer_q <= xfer_d; rla_q <= rla_d; revert_q <= revert_d;
                link_q <= link_d; pio_t_q <= pio_t_d; dma_t_q <= dma_t_d;
            end
            if (full_w) wce_q <= 1'b0;
            else if (commit_w) wce_q <= wce_d;
        end
    end

    // power management level and idle delays
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= '0; pm_q <= PM_IDLE; y1_q <= '0; y2_q <= '0; y1set_q <= 1'b0;
        end else if (apm_init_w) begin
            lvl_q <= '0; pm_q <= PM_IDLE; y1_q <= '0; y2_q <= '0; y1set_q <= 1'b0;
        end else if (commit_w) begin
            lvl_q <= lvl_d; pm_q <= pm_d; y1_q <= y1_d; y2_q <= y2_d; y1set_q <= y1set_d;
        end
    end

    // power condition timers, indexed by condition
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_t_q <= '{EPC_DEF_T0, EPC_DEF_T1};
            sav_t_q <= '{EPC_DEF_T0, EPC_DEF_T1};
            cur_e_q <= EPC_DEF_EN;
            sav_e_q <= EPC_DEF_EN;
        end else if (commit_w) begin
            cur_t_q <= cur_t_d;
            sav_t_q <= sav_t_d;
            cur_e_q <= cur_e_d;
        end
    end
endmodule

// ---- setfeat_pkg.sv ----
// Purpose: constants and types for the set-features subcommand decoder
// Assumes: APB register map, 32-bit data, one word per register
// Notes:   idle delays are kept in seconds, EPC timers in 100 ms units
// Overview of operation
// - transfer type upper five, mode lower three
// - PIO default modes 0-1, flow PIO 0-4
// - multiword DMA 0-2, Ultra DMA 0-6
// - reassign capacity full forces write cache off
// - 10h enables, 90h disables link feature
// - link feature ids 01h-04h and 06h accepted
// - APM level from count, 00h/FFh abort
// - level ranges pick idle, low-power, low-rpm
// - low-power delay (x-80h)*5+120 seconds, no low-rpm
// - levels 40h-7Fh: low-rpm delay (x-40h)*60+600
// - levels 01h-3Fh: low-rpm delay fixed 600
// - low-rpm keeps set low-power delay, else 120
// - APM state kept; reset, and soft reset after CCh enables reverting, reinitialise
// - 43h takes PIO and DMA sector times
// - zero sector time means full mode rate
// - restore: id in count, subcommand bits zero
// - default bit set copies default to current
// - default bit clear copies saved to current
// - save bit copies current timer to saved
// - restore aborts on unsupported, disabled, unsavable
// - 4Ah routes to power condition subcommands
// - undefined feature code sets abort
package setfeat_pkg;
    // command and feature codes
    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
    localparam logic [7:0] FC_WCACHE_ON     = 8'h02;
    localparam logic [7:0] FC_XFER_MODE     = 8'h03;
    localparam logic [7:0] FC_APM_ON        = 8'h05;
    localparam logic [7:0] FC_PUIS_ON       = 8'h06;
    localparam logic [7:0] FC_PUIS_SPIN     = 8'h07;
    localparam logic [7:0] FC_LINK_ON       = 8'h10;
    localparam logic [7:0] FC_SECTOR_TIME   = 8'h43;
    localparam logic [7:0] FC_EPC           = 8'h4A;
    localparam logic [7:0] FC_RLA_OFF       = 8'h55;
    localparam logic [7:0] FC_REVERT_OFF    = 8'h66;
    localparam logic [7:0] FC_WCACHE_OFF    = 8'h82;
    localparam logic [7:0] FC_APM_OFF       = 8'h85;
    localparam logic [7:0] FC_PUIS_OFF      = 8'h86;
    localparam logic [7:0] FC_LINK_OFF      = 8'h90;
    localparam logic [7:0] FC_RLA_ON        = 8'hAA;
    localparam logic [7:0] FC_REVERT_ON     = 8'hCC;
    // transfer types and highest mode of each
    localparam logic [4:0] XT_PIO_DEF   = 5'h00;
    localparam logic [4:0] XT_PIO_FC    = 5'h01;
    localparam logic [4:0] XT_MDMA      = 5'h04;
    localparam logic [4:0] XT_UDMA      = 5'h08;
    localparam logic [2:0] PIO_DEF_MAX  = 3'h1;
    localparam logic [2:0] PIO_FC_MAX   = 3'h4;
    localparam logic [2:0] MDMA_MAX     = 3'h2;
    localparam logic [2:0] UDMA_MAX     = 3'h6;
    localparam logic [7:0] XFER_RESET   = 8'h00;
    // serial link feature ids 1,2,3,4,6
    localparam logic [7:0] LINK_ID_OK   = 8'h5E;
    localparam logic [7:0] LINK_RESET   = 8'h00;
    // power management levels and delays (seconds)
    localparam logic [7:0]  LVL_ABORT_LO = 8'h00;
    localparam logic [7:0]  LVL_ABORT_HI = 8'hFF;
    localparam logic [7:0]  LVL_IDLE_LO  = 8'hC0;
    localparam logic [7:0]  LVL_LPI_LO   = 8'h80;
    localparam logic [7:0]  LVL_LRPM_MID = 8'h40;
    localparam logic [8:0]  Y1_STEP_S    = 9'h005;
    localparam logic [8:0]  Y1_BASE_S    = 9'h078;
    localparam logic [12:0] Y2_STEP_S    = 13'h003C;
    localparam logic [12:0] Y2_BASE_S    = 13'h0258;
    typedef enum logic [1:0] {PM_IDLE, PM_LPI, PM_LRPM} pm_state_t;
    // extended power conditions
    localparam int          EPC_N        = 2;
    localparam int          EPC_IW       = 1;
    localparam int          EPC_TW       = 24;
    localparam logic [3:0]  EPC_SUB_RST  = 4'h0;
    localparam logic [7:0]  EPC_ALL_IDS  = 8'hFF;
    localparam int          SN_DFLT_BIT  = 6;
    localparam int          SN_SAVE_BIT  = 4;
    localparam logic [1:0]  EPC_SUPP     = 2'h3;
    localparam logic [1:0]  EPC_CHG      = 2'h3;
    localparam logic [1:0]  EPC_SAVABLE  = 2'h1;
    localparam logic [1:0]  EPC_DEF_EN   = 2'h3;
    localparam logic [23:0] EPC_DEF_T0   = 24'h0000C8;
    localparam logic [23:0] EPC_DEF_T1   = 24'h000BB8;
    // status and error bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_RDY  = 6;
    localparam int ST_SEEK = 4;
    localparam int ST_ERR  = 0;
    localparam int ER_ABT  = 2;
    // control register bits
    localparam int CTL_FULL  = 0;
    localparam int CTL_EPC   = 1;
    localparam int CTL_SRST  = 2;
    // register byte addresses
    localparam logic [7:0] A_FEATURE = 8'h00;
    localparam logic [7:0] A_SECCNT  = 8'h04;
    localparam logic [7:0] A_SECNUM  = 8'h08;
    localparam logic [7:0] A_LBALO   = 8'h0C;
    localparam logic [7:0] A_LBAMID  = 8'h10;
    localparam logic [7:0] A_LBAHI   = 8'h14;
    localparam logic [7:0] A_COMMAND = 8'h18;
    localparam logic [7:0] A_STATUS  = 8'h1C;
    localparam logic [7:0] A_ERROR   = 8'h20;
    localparam logic [7:0] A_XFER    = 8'h24;
    localparam logic [7:0] A_FEATST  = 8'h28;
    localparam logic [7:0] A_APM     = 8'h2C;
    localparam logic [7:0] A_DELAYS  = 8'h30;
    localparam logic [7:0] A_SECTIME = 8'h34;
    localparam logic [7:0] A_CONTROL = 8'h38;
    localparam logic [7:0] A_EPC_IDX = 8'h3C;
    localparam logic [7:0] A_EPC_CUR = 8'h40;
    localparam logic [7:0] A_EPC_SAV = 8'h44;
endpackage

// ---- sfd_asserts.sv ----
// Purpose: port checks for the set-features decoder
// Assumes: zero-wait APB slave, read data judged at the access edge
// Notes:   bound to the decoder from the testbench top
module sfd_asserts
    import setfeat_pkg::*;
(
    input logic        clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // read access completing at this edge
    wire rd_go = psel && penable && !pwrite && pready;
    // legal transfer type and mode pairs
    function automatic logic mode_ok(input logic [7:0] v);
        case (v[7:3])
            XT_PIO_DEF: mode_ok = (v[2:0] <= PIO_DEF_MAX);
            XT_PIO_FC:  mode_ok = (v[2:0] <= PIO_FC_MAX);
            XT_MDMA:    mode_ok = (v[2:0] <= MDMA_MAX);
            XT_UDMA:    mode_ok = (v[2:0] <= UDMA_MAX);
            default:    mode_ok = 1'b0;
        endcase
    endfunction
    // bus answer
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    a_slverr_map: assert property (psel && penable |->
        pslverr == (paddr > A_EPC_SAV || paddr[1:0] != 2'h0)) else $error("bad slave error");
    // completion flags and decoded settings
    a_status_flags: assert property (rd_go && paddr == A_STATUS |-> prdata[31:1] == 31'h28)
        else $error("status flags wrong");
    a_error_bits: assert property (rd_go && paddr == A_ERROR |-> (prdata & 32'hFFFFFFFB) == 0)
        else $error("error flags beyond abort");
    a_xfer_legal: assert property (rd_go && paddr == A_XFER |-> mode_ok(prdata[7:0]))
        else $error("illegal transfer mode held");
    a_link_ids: assert property (rd_go && paddr == A_FEATST |-> !prdata[0] && !prdata[5] && !prdata[7])
        else $error("unknown link feature enabled");
    a_apm_level: assert property (rd_go && paddr == A_APM |-> prdata[7:0] != LVL_ABORT_HI)
        else $error("abort level stored");
    a_apm_state: assert property (rd_go && paddr == A_APM |-> prdata[9:8] ==
        ((prdata[7:0] >= LVL_IDLE_LO || prdata[7:0] == 0) ? 2'h0 : (prdata[7] ? 2'h1 : 2'h2)))
        else $error("power state does not match level");
    a_lp_range: assert property (rd_go && paddr == A_DELAYS |-> prdata[8:0] == 0 ||
        (prdata[8:0] >= 120 && prdata[8:0] <= 435 && (prdata[8:0] - 120) % 5 == 0))
        else $error("low-power delay off grid");
    a_lrpm_range: assert property (rd_go && paddr == A_DELAYS |-> prdata[28:16] == 0 ||
        (prdata[28:16] >= 600 && prdata[28:16] <= 4380 && prdata[28:16] % 60 == 0))
        else $error("low-rpm delay off grid");
    c_abort: cover property (rd_go && paddr == A_STATUS && prdata[0]);
    c_lrpm: cover property (rd_go && paddr == A_APM && prdata[9:8] == 2'h2);
    c_slverr: cover property (psel && penable && pslverr);
endmodule

// ---- sfd_host_model.sv ----
// Purpose: host side APB master issuing set-features commands
// Assumes: tasks are entered just after a rising clock edge
// Notes:   write data is inverted when released so stale data never matches
module sfd_host_model
    import setfeat_pkg::*;
(
    input  logic        clk,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata,
    input  logic [31:0] prdata,
    input  logic        pready,
    input  logic        pslverr
);
    // idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    // one transfer: setup, access held until ready, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
        @(posedge clk);
    endtask
    // load the task file, then the command byte
    task automatic issue(input logic [7:0] fc, sc, sn, lo, mid, hi);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, A_FEATURE, {24'h0, fc}, q, e);
        xfer(1'b1, A_SECCNT, {24'h0, sc}, q, e);
        xfer(1'b1, A_SECNUM, {24'h0, sn}, q, e);
        xfer(1'b1, A_LBALO, {24'h0, lo}, q, e);
        xfer(1'b1, A_LBAMID, {24'h0, mid}, q, e);
        xfer(1'b1, A_LBAHI, {24'h0, hi}, q, e);
        xfer(1'b1, A_COMMAND, {24'h0, CMD_SET_FEATURES}, q, e);
    endtask
endmodule

// ---- tb_set_features_subcommand_decoder.sv ----
// Purpose: self-checking bench for the set-features decoder
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes:   every scenario reads results back over APB
module tb_set_features_subcommand_decoder
    import setfeat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    always #12.5 clk = ~clk;
    sfd_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    set_features_subcommand_decoder dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(n, exp, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b1, a, d, q, e);
    endtask
    // issue a command and judge status and error
    task automatic run(input logic [7:0] fc, sc, sn, input logic ab);
        host.issue(fc, sc, sn, 8'h00, 8'h00, 8'h00);
        rchk("status", A_STATUS, {31'h28, ab});
        rchk("error", A_ERROR, {29'h0, ab, 2'h0});
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        rchk("status", A_STATUS, 32'h50);
        rchk("featst", A_FEATST, 32'h300);
        host.xfer(1'b0, 8'h48, 32'h0, q, e);
        chk("slverr", 32'h1, {31'h0, e});
    endtask
    task automatic t_xfer();
        logic [4:0] ty [4] = '{XT_PIO_DEF, XT_PIO_FC, XT_MDMA, XT_UDMA};
        logic [2:0] mx [4] = '{PIO_DEF_MAX, PIO_FC_MAX, MDMA_MAX, UDMA_MAX};
        for (int i = 0; i < 4; i++) begin
            run(FC_XFER_MODE, {ty[i], mx[i]}, 8'h00, 1'b0);
            run(FC_XFER_MODE, {ty[i], mx[i] + 3'h1}, 8'h00, 1'b1);
            rchk("xfer", A_XFER, {24'h0, ty[i], mx[i]});
        end
        run(FC_XFER_MODE, 8'h10, 8'h00, 1'b1);
    endtask
    task automatic t_cache_link();
        wr(A_CONTROL, 32'h1);
        run(FC_WCACHE_ON, 8'h00, 8'h00, 1'b0);
        rchk("featst", A_FEATST, 32'h200);
        wr(A_CONTROL, 32'h0);
        run(FC_WCACHE_ON, 8'h00, 8'h00, 1'b0);
        for (int i = 1; i < 8; i++) begin
            run(FC_LINK_ON, 8'(i), 8'h00, i == 5 || i == 7);
        end
        rchk("featst", A_FEATST, 32'h35E);
        run(FC_LINK_OFF, 8'h03, 8'h00, 1'b0);
        run(FC_LINK_OFF, 8'h00, 8'h00, 1'b1);
        rchk("featst", A_FEATST, 32'h356);
        run(FC_WCACHE_OFF, 8'h00, 8'h00, 1'b0);
        run(FC_RLA_OFF, 8'h00, 8'h00, 1'b0);
        run(FC_PUIS_ON, 8'h00, 8'h00, 1'b0);
        rchk("featst", A_FEATST, 32'h056);
    endtask
    task automatic t_apm();
        logic [7:0]  lv [8] = '{8'h00, 8'hFF, 8'h80, 8'hBF, 8'h7F, 8'hC0, 8'h3F, 8'h40};
        logic [9:0]  ap [8] = '{10'h0, 10'h0, 10'h180, 10'h1BF, 10'h27F, 10'h0C0, 10'h23F, 10'h240};
        logic [31:0] dl [8] = '{0, 0, 32'h78, 32'h1B3, 32'h111C01B3, 0, 32'h2580078, 32'h2580078};
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            run(FC_APM_ON, lv[i], 8'h00, i < 2);
            rchk("apm", A_APM, {22'h0, ap[i]});
            host.xfer(1'b0, A_DELAYS, 32'h0, q, e);
            chk("delays", dl[i], (i == 2 || i == 3) ? q & 32'h1FF : q);
        end
        wr(A_CONTROL, 32'h4);
        rchk("apm", A_APM, 32'h240);
        run(FC_REVERT_ON, 8'h00, 8'h00, 1'b0);
        wr(A_CONTROL, 32'h4);
        rchk("apm", A_APM, 32'h0);
        rchk("delays", A_DELAYS, 32'h0);
        run(FC_APM_ON, 8'h90, 8'h00, 1'b0);
        rchk("delays", A_DELAYS, 32'hC8);
        run(FC_APM_OFF, 8'h00, 8'h00, 1'b0);
        rchk("delays", A_DELAYS, 32'h0);
        run(FC_REVERT_OFF, 8'h00, 8'h00, 1'b0);
        rchk("featst", A_FEATST, 32'h056);
    endtask
    task automatic t_time_epc();
        host.issue(FC_SECTOR_TIME, 8'h34, 8'h00, 8'h12, 8'h78, 8'h56);
        rchk("sectime", A_SECTIME, 32'h56781234);
        run(FC_SECTOR_TIME, 8'h00, 8'h00, 1'b0);
        rchk("sectime", A_SECTIME, 32'h0);
        run(FC_EPC, 8'h00, 8'h40, 1'b1);
        wr(A_CONTROL, 32'h2);
        run(FC_EPC, 8'h00, 8'h01, 1'b1);
        run(FC_EPC, 8'h01, 8'h10, 1'b1);
        run(FC_EPC, 8'h02, 8'h40, 1'b1);
        run(FC_EPC, 8'h00, 8'h50, 1'b0);
        rchk("epc cur", A_EPC_CUR, {8'h01, EPC_DEF_T0});
        rchk("epc sav", A_EPC_SAV, {8'h01, EPC_DEF_T0});
        run(FC_EPC, 8'hFF, 8'h40, 1'b0);
        run(FC_EPC, 8'h01, 8'h00, 1'b0);
        wr(A_EPC_IDX, 32'h1);
        rchk("epc cur", A_EPC_CUR, {8'h01, EPC_DEF_T1});
        run(8'h01, 8'h00, 8'h00, 1'b1);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_xfer();
        t_cache_link();
        t_apm();
        t_time_epc();
        close_out();
    end
endmodule
bind set_features_subcommand_decoder sfd_asserts chk_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
